// [src/scb_pkg.sv]
// Constants for the sync, transmit, clock-output and packet configuration bank.
// Assumes an 8-bit register port with hexadecimal register addresses.
package scb_pkg;

  // Register addresses
  localparam logic [7:0] SCB_ADDR_SYNC_DETECT = 8'h12;
  localparam logic [7:0] SCB_ADDR_SYNC_BYTE3  = 8'h16;
  localparam logic [7:0] SCB_ADDR_SYNC_BYTE2  = 8'h17;
  localparam logic [7:0] SCB_ADDR_SYNC_BYTE1  = 8'h18;
  localparam logic [7:0] SCB_ADDR_SYNC_BYTE0  = 8'h19;
  localparam logic [7:0] SCB_ADDR_TX_SET      = 8'h1A;
  localparam logic [7:0] SCB_ADDR_CLKOUT_SET  = 8'h1B;
  localparam logic [7:0] SCB_ADDR_CODING_LEN  = 8'h1C;
  localparam logic [7:0] SCB_ADDR_NODE        = 8'h1D;
  localparam logic [7:0] SCB_ADDR_PKT_FORMAT  = 8'h1E;
  localparam logic [7:0] SCB_ADDR_FIFO_CTRL   = 8'h1F;

  // Reset values
  localparam logic [7:0] SCB_RST_SYNC_DETECT = 8'h18;
  localparam logic [7:0] SCB_RST_SYNC_BYTE   = 8'h00;
  localparam logic [7:0] SCB_RST_TX_SET      = 8'h72;
  localparam logic [7:0] SCB_RST_CLKOUT_SET  = 8'hBC;
  localparam logic [7:0] SCB_RST_CODING_LEN  = 8'h00;
  localparam logic [7:0] SCB_RST_NODE        = 8'h00;
  localparam logic [7:0] SCB_RST_PKT_FORMAT  = 8'h48;
  localparam logic [7:0] SCB_RST_FIFO_CTRL   = 8'h00;

  // Field positions
  localparam int SCB_POS_SYNC_ON     = 5;
  localparam int SCB_POS_SYNC_SIZE   = 3;
  localparam int SCB_POS_SYNC_TOL    = 1;
  localparam int SCB_POS_INTERP      = 4;
  localparam int SCB_POS_POUT        = 1;
  localparam int SCB_POS_CLKOUT_ON   = 7;
  localparam int SCB_POS_CLKOUT_DIV  = 2;
  localparam int SCB_POS_MANCHESTER  = 7;
  localparam int SCB_POS_PAYLOAD     = 0;
  localparam int SCB_POS_PKT_VAR     = 7;
  localparam int SCB_POS_PREAMBLE    = 5;
  localparam int SCB_POS_WHITEN      = 4;
  localparam int SCB_POS_CRC_ON      = 3;
  localparam int SCB_POS_ADDR_FILT   = 1;
  localparam int SCB_POS_CRC_STATUS  = 0;
  localparam int SCB_POS_AUTOCLR_OFF = 7;
  localparam int SCB_POS_STBY_READ   = 6;

  // Sync length codes
  localparam logic [1:0] SCB_SYNC_8  = 2'h0;
  localparam logic [1:0] SCB_SYNC_32 = 2'h3;

  // Address filter modes
  typedef enum logic [1:0] {
    SCB_FILT_OFF   = 2'h0,
    SCB_FILT_NODE  = 2'h1,
    SCB_FILT_NODE0 = 2'h2,
    SCB_FILT_ALL3  = 2'h3
  } scb_filt_t;

  localparam logic [7:0] SCB_BCAST_ZERO = 8'h00;
  localparam logic [7:0] SCB_BCAST_ONES = 8'hFF;

endpackage : scb_pkg

// [src/scb_clkdiv.sv]
// Clock output generator for the configuration bank.
// Assumes the system clock stands in for the crystal reference.
`timescale 1ns/100ps
`default_nettype none

module scb_clkdiv
  import scb_pkg::*;
#(
  parameter int DIV_W = 5
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Settings
  input  wire logic             enable,
  input  wire logic [DIV_W-1:0] divider,
  // Pin
  output var  logic             clk_out
);

  logic [DIV_W-1:0] cnt_q;
  logic             clk_out_q;

  // Half period of divider cycles gives reference over twice the field
  always_ff @(posedge clk)
  begin
    if (rst || !enable)
    begin
      cnt_q     <= '0;
      clk_out_q <= 1'b0; // Pin held low while disabled
    end
    else if (divider == '0)
    begin
      cnt_q     <= '0;
      clk_out_q <= ~clk_out_q; // Fastest a flop can go
    end
    else if (cnt_q >= divider - 1'b1)
    begin
      cnt_q     <= '0;
      clk_out_q <= ~clk_out_q;
    end
    else
    begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign clk_out = clk_out_q;

endmodule // scb_clkdiv

`default_nettype wire

// [src/scb_addr_filter.sv]
// Receive address filter: compares a packet address with the node address.
// Assumes the address arrives as a one-cycle strobe with its byte.
`timescale 1ns/100ps
`default_nettype none

module scb_addr_filter
  import scb_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Settings
  input  wire logic [1:0] mode,
  input  wire logic [7:0] node_addr,
  // Incoming address
  input  wire logic       addr_valid,
  input  wire logic [7:0] addr,
  // Verdict
  output var  logic       accept,
  output var  logic       reject
);

  logic hit;
  logic accept_q;
  logic reject_q;

  // Accept set grows with the mode code from 1 to 3; mode 0 accepts every address
  always_comb
  begin
    unique case (scb_filt_t'(mode))
      SCB_FILT_OFF:   hit = 1'b1;
      SCB_FILT_NODE:  hit = (addr == node_addr);
      SCB_FILT_NODE0: hit = (addr == node_addr) || (addr == SCB_BCAST_ZERO);
      SCB_FILT_ALL3:  hit = (addr == node_addr) || (addr == SCB_BCAST_ZERO)
                            || (addr == SCB_BCAST_ONES);
    endcase
  end

  // One-cycle verdict pulses
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      accept_q <= 1'b0;
      reject_q <= 1'b0;
    end
    else
    begin
      accept_q <= addr_valid && hit;
      reject_q <= addr_valid && !hit;
    end
  end

  assign accept = accept_q;
  assign reject = reject_q;

endmodule // scb_addr_filter

`default_nettype wire

// [src/scb_regbank.sv]
// Configuration register bank: sync word, transmit, clock output and packet
// handler settings, reached over the device's register port.
// Assumes the serial port front end delivers decoded byte reads and writes.
`timescale 1ns/100ps
`default_nettype none

module scb_regbank
  import scb_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  // Register port
  input  wire logic        CFG_WR,
  input  wire logic        CFG_RD,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [7:0]  CFG_WDATA,
  output var  logic [7:0]  CFG_RDATA,
  output var  logic        CFG_RVALID,
  // Sync detector settings
  output var  logic        SYNC_ENABLE,
  output var  logic [1:0]  SYNC_TOLERANCE,
  output var  logic [31:0] SYNC_WORD,
  output var  logic [31:0] SYNC_MASK,
  // Transmit settings
  output var  logic [3:0]  TX_INTERP_CUTOFF,
  output var  logic [2:0]  TX_POWER,
  // Clock output pin
  output var  logic        CLK_OUT,
  // Packet handler settings
  output var  logic        MANCHESTER_EN,
  output var  logic        PKT_VARIABLE,
  output var  logic [6:0]  PAYLOAD_LEN,
  output var  logic [1:0]  PREAMBLE_SIZE,
  output var  logic        WHITEN_EN,
  output var  logic        CRC_EN,
  output var  logic        FIFO_STBY_READ,
  // Receive length check
  input  wire logic        RX_LEN_VALID,
  input  wire logic [6:0]  RX_LEN,
  output var  logic        RX_LEN_ERROR,
  // Address filter
  input  wire logic        RX_ADDR_VALID,
  input  wire logic [7:0]  RX_ADDR,
  output var  logic        ADDR_ACCEPT,
  output var  logic        ADDR_REJECT,
  // CRC result and FIFO clearing
  input  wire logic        CRC_DONE,
  input  wire logic        CRC_PASS,
  output var  logic        FIFO_CLEAR
);

  // Register storage
  logic [7:0]  sync_det_q;
  logic [7:0]  sync_b3_q;
  logic [7:0]  sync_b2_q;
  logic [7:0]  sync_b1_q;
  logic [7:0]  sync_b0_q;
  logic [7:0]  tx_set_q;
  logic [7:0]  clk_set_q;
  logic [7:0]  coding_q;
  logic [7:0]  node_q;
  logic [7:0]  pkt_fmt_q;
  logic [7:0]  fifo_ctl_q;
  logic        crc_stat_q;

  // Derived settings, registered to keep outputs flop driven
  logic [7:0]  rdata_q;
  logic        rvalid_q;
  logic [31:0] sync_mask_q;
  logic        len_err_q;
  logic        fifo_clr_q;
  logic [7:0]  rdata_d;
  logic [31:0] sync_mask_d;

  // Match the write strobe against one address
  function automatic logic wr_hit(input logic [7:0] a);
    return CFG_WR && (CFG_ADDR == a);
  endfunction

  // Sync group and word bytes
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      sync_det_q <= SCB_RST_SYNC_DETECT;
      sync_b3_q  <= SCB_RST_SYNC_BYTE;
      sync_b2_q  <= SCB_RST_SYNC_BYTE;
      sync_b1_q  <= SCB_RST_SYNC_BYTE;
      sync_b0_q  <= SCB_RST_SYNC_BYTE;
    end
    else
    begin
      if (wr_hit(SCB_ADDR_SYNC_DETECT))
        sync_det_q <= CFG_WDATA;
      if (wr_hit(SCB_ADDR_SYNC_BYTE3))
        sync_b3_q <= CFG_WDATA;
      if (wr_hit(SCB_ADDR_SYNC_BYTE2))
        sync_b2_q <= CFG_WDATA;
      if (wr_hit(SCB_ADDR_SYNC_BYTE1))
        sync_b1_q <= CFG_WDATA;
      if (wr_hit(SCB_ADDR_SYNC_BYTE0))
        sync_b0_q <= CFG_WDATA;
    end
  end

  // Transmit and clock output settings
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      tx_set_q  <= SCB_RST_TX_SET;
      clk_set_q <= SCB_RST_CLKOUT_SET;
    end
    else
    begin
      if (wr_hit(SCB_ADDR_TX_SET))
        tx_set_q <= CFG_WDATA;
      if (wr_hit(SCB_ADDR_CLKOUT_SET))
        clk_set_q <= CFG_WDATA;
    end
  end

  // Packet handler settings
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      coding_q   <= SCB_RST_CODING_LEN;
      node_q     <= SCB_RST_NODE;
      pkt_fmt_q  <= SCB_RST_PKT_FORMAT;
      fifo_ctl_q <= SCB_RST_FIFO_CTRL;
    end
    else
    begin
      if (wr_hit(SCB_ADDR_CODING_LEN))
        coding_q <= CFG_WDATA;
      if (wr_hit(SCB_ADDR_NODE))
        node_q <= CFG_WDATA;
      // Status bit position is never stored from a write
      if (wr_hit(SCB_ADDR_PKT_FORMAT))
        pkt_fmt_q <= {CFG_WDATA[7:1], 1'b0};
      if (wr_hit(SCB_ADDR_FIFO_CTRL))
        fifo_ctl_q <= CFG_WDATA;
    end
  end

  // CRC result of the latest packet, held until the next one
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      crc_stat_q <= 1'b0;
    else if (CRC_DONE)
      crc_stat_q <= CRC_PASS;
  end

  // Clear the FIFO on a failed check unless auto clear is off
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      fifo_clr_q <= 1'b0;
    else
      fifo_clr_q <= CRC_DONE && !CRC_PASS && pkt_fmt_q[SCB_POS_CRC_ON]
                    && !fifo_ctl_q[SCB_POS_AUTOCLR_OFF];
  end

  // Received length against the limit; fixed format wants an exact match
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      len_err_q <= 1'b0;
    else if (pkt_fmt_q[SCB_POS_PKT_VAR])
      len_err_q <= RX_LEN_VALID && (RX_LEN > coding_q[6:0]);
    else
      len_err_q <= RX_LEN_VALID && (RX_LEN != coding_q[6:0]);
  end

  // Bytes that take part in sync matching, first byte always
  always_comb
  begin
    sync_mask_d = 32'hFF00_0000;
    if (sync_det_q[SCB_POS_SYNC_SIZE +: 2] != SCB_SYNC_8)
      sync_mask_d[23:16] = 8'hFF;
    if (sync_det_q[SCB_POS_SYNC_SIZE + 1])
      sync_mask_d[15:8] = 8'hFF;
    if (sync_det_q[SCB_POS_SYNC_SIZE +: 2] == SCB_SYNC_32)
      sync_mask_d[7:0] = 8'hFF;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      sync_mask_q <= 32'hFFFF_FFFF;
    else
      sync_mask_q <= sync_mask_d;
  end

  // Read multiplexer; unmapped addresses read as zero
  always_comb
  begin
    unique case (CFG_ADDR)
      SCB_ADDR_SYNC_DETECT: rdata_d = sync_det_q;
      SCB_ADDR_SYNC_BYTE3:  rdata_d = sync_b3_q;
      SCB_ADDR_SYNC_BYTE2:  rdata_d = sync_b2_q;
      SCB_ADDR_SYNC_BYTE1:  rdata_d = sync_b1_q;
      SCB_ADDR_SYNC_BYTE0:  rdata_d = sync_b0_q;
      SCB_ADDR_TX_SET:      rdata_d = tx_set_q;
      SCB_ADDR_CLKOUT_SET:  rdata_d = clk_set_q;
      SCB_ADDR_CODING_LEN:  rdata_d = coding_q;
      SCB_ADDR_NODE:        rdata_d = node_q;
      SCB_ADDR_PKT_FORMAT:  rdata_d = {pkt_fmt_q[7:1], crc_stat_q};
      SCB_ADDR_FIFO_CTRL:   rdata_d = fifo_ctl_q;
      default:              rdata_d = 8'h00;
    endcase
  end

  // Read data one cycle after the strobe
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= CFG_RD;
      if (CFG_RD)
        rdata_q <= rdata_d;
    end
  end

  // Clock output pin
  scb_clkdiv #(
    .DIV_W   (5)
  ) u_clkdiv (
    .clk     (CLK_SYS),
    .rst     (SYS_RST),
    .enable  (clk_set_q[SCB_POS_CLKOUT_ON]),
    .divider (clk_set_q[SCB_POS_CLKOUT_DIV +: 5]),
    .clk_out (CLK_OUT)
  );

  // Receive address filtering against the node address
  scb_addr_filter u_filter (
    .clk        (CLK_SYS),
    .rst        (SYS_RST),
    .mode       (pkt_fmt_q[SCB_POS_ADDR_FILT +: 2]),
    .node_addr  (node_q),
    .addr_valid (RX_ADDR_VALID),
    .addr       (RX_ADDR),
    .accept     (ADDR_ACCEPT),
    .reject     (ADDR_REJECT)
  );

  // Outputs straight from the storage and derived-setting flops
  assign CFG_RDATA        = rdata_q;
  assign CFG_RVALID       = rvalid_q;
  assign SYNC_ENABLE      = sync_det_q[SCB_POS_SYNC_ON];
  assign SYNC_TOLERANCE   = sync_det_q[SCB_POS_SYNC_TOL +: 2];
  assign SYNC_WORD        = {sync_b3_q, sync_b2_q, sync_b1_q, sync_b0_q};
  assign SYNC_MASK        = sync_mask_q;
  assign TX_INTERP_CUTOFF = tx_set_q[SCB_POS_INTERP +: 4];
  assign TX_POWER         = tx_set_q[SCB_POS_POUT +: 3];
  assign MANCHESTER_EN    = coding_q[SCB_POS_MANCHESTER];
  assign PAYLOAD_LEN      = coding_q[SCB_POS_PAYLOAD +: 7];
  assign PKT_VARIABLE     = pkt_fmt_q[SCB_POS_PKT_VAR];
  assign PREAMBLE_SIZE    = pkt_fmt_q[SCB_POS_PREAMBLE +: 2];
  assign WHITEN_EN        = pkt_fmt_q[SCB_POS_WHITEN];
  assign CRC_EN           = pkt_fmt_q[SCB_POS_CRC_ON];
  assign FIFO_STBY_READ   = fifo_ctl_q[SCB_POS_STBY_READ];
  assign RX_LEN_ERROR     = len_err_q;
  assign FIFO_CLEAR       = fifo_clr_q;

endmodule // scb_regbank

`default_nettype wire

// [test/scb_checker.sv]
// Port checker for scb_regbank, bound onto the design below.
// Assumes register shadows start from the package reset values.
`timescale 1ns/100ps
`default_nettype none
module scb_checker
  import scb_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        SYS_RST,
  // Register port
  input wire logic        CFG_WR,
  input wire logic        CFG_RD,
  input wire logic [7:0]  CFG_ADDR,
  input wire logic [7:0]  CFG_WDATA,
  input wire logic [7:0]  CFG_RDATA,
  input wire logic        CFG_RVALID,
  // Settings and events
  input wire logic [31:0] SYNC_MASK,
  input wire logic        CLK_OUT,
  input wire logic        CRC_EN,
  input wire logic        RX_ADDR_VALID,
  input wire logic [7:0]  RX_ADDR,
  input wire logic        ADDR_ACCEPT,
  input wire logic        ADDR_REJECT,
  input wire logic        CRC_DONE,
  input wire logic        CRC_PASS,
  input wire logic        FIFO_CLEAR
);
  logic [7:0] sh_q [27:31];
  logic       prev_q;
  logic [7:0] run_q;
  logic [7:0] quiet_q;
  wire  [4:0] div = sh_q[27][6:2];
  wire  [7:0] rsh = sh_q[CFG_ADDR[4:0]];
  wire        acc = sh_q[30][2:1] == 2'h0 || RX_ADDR == sh_q[29]
                    || (sh_q[30][2] && RX_ADDR == 8'h00)
                    || (sh_q[30][2:1] == 2'h3 && RX_ADDR == 8'hFF);
  // Shadow of registers 27 to 31, reserved bits as written
  always_ff @(posedge CLK_SYS)
    if (SYS_RST)
    begin
      sh_q[27] <= SCB_RST_CLKOUT_SET;
      sh_q[28] <= SCB_RST_CODING_LEN;
      sh_q[29] <= SCB_RST_NODE;
      sh_q[30] <= SCB_RST_PKT_FORMAT;
      sh_q[31] <= SCB_RST_FIFO_CTRL;
    end
    else if (CFG_WR && CFG_ADDR >= 8'h1B && CFG_ADDR <= 8'h1F)
      sh_q[CFG_ADDR[4:0]] <= CFG_WDATA;
  // Clock output run length; quiet time lets a new divider settle
  always_ff @(posedge CLK_SYS)
    if (SYS_RST)
    begin
      prev_q  <= 1'b0;
      run_q   <= 8'h00;
      quiet_q <= 8'h00;
    end
    else
    begin
      prev_q  <= CLK_OUT;
      run_q   <= (CLK_OUT != prev_q) ? 8'h01 : run_q + {7'h00, run_q != 8'hFF};
      quiet_q <= (CFG_WR && CFG_ADDR == SCB_ADDR_CLKOUT_SET) ? 8'h00
                 : quiet_q + {7'h00, quiet_q != 8'hFF};
    end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // Size field of the byte on the write bus; helper avoids local variables
  wire  [1:0] wsz = CFG_WDATA[SCB_POS_SYNC_SIZE +: 2];
  // Write of the sync settings; the idle cycle after it is added in p_mask
  sequence s_size;
    CFG_WR && CFG_ADDR == SCB_ADDR_SYNC_DETECT;
  endsequence
  // Clock output switched off, then no further write for two cycles
  sequence s_off;
    (CFG_WR && CFG_ADDR == SCB_ADDR_CLKOUT_SET && !CFG_WDATA[7]) ##1 !CFG_WR [*2];
  endsequence
  property p_mask;
    s_size ##1 !CFG_WR |=> SYNC_MASK == ~(32'hFFFF_FFFF >> (8 * ($past(wsz, 2) + 1)));
  endproperty
  AST_RD_VALID: assert property (CFG_RD |=> CFG_RVALID)
    else $error("read not answered");
  AST_NO_VALID: assert property (!CFG_RD |=> !CFG_RVALID)
    else $error("read valid without read");
  AST_RD_DATA: assert property (CFG_RD && CFG_ADDR inside {8'h1B, 8'h1C, 8'h1D, 8'h1F}
    |=> CFG_RDATA == $past(rsh)) else $error("read data wrong");
  AST_SYNC_MASK: assert property (p_mask)
    else $error("sync byte mask wrong");
  AST_CLK_OFF: assert property (s_off |-> !CLK_OUT)
    else $error("clock output not off");
  AST_CLK_DIV: assert property (CLK_OUT != prev_q && quiet_q > 8'h46 && sh_q[27][7]
    |-> run_q == ((div == 5'h00) ? 8'h01 : {3'h0, div})) else $error("clock output period");
  AST_FIFO_CLR: assert property (CRC_DONE && !CRC_PASS && CRC_EN && !sh_q[31][7]
    |=> FIFO_CLEAR) else $error("fifo not cleared");
  AST_NO_CLR: assert property (!(CRC_DONE && !CRC_PASS && CRC_EN && !sh_q[31][7])
    |=> !FIFO_CLEAR) else $error("stray fifo clear");
  AST_ADDR_FILT: assert property (RX_ADDR_VALID
    |=> ADDR_ACCEPT == $past(acc) && ADDR_REJECT == !$past(acc)) else $error("filter verdict");
endmodule // scb_checker
bind scb_regbank scb_checker chk (
  .CLK_SYS       (CLK_SYS),
  .SYS_RST       (SYS_RST),
  .CFG_WR        (CFG_WR),
  .CFG_RD        (CFG_RD),
  .CFG_ADDR      (CFG_ADDR),
  .CFG_WDATA     (CFG_WDATA),
  .CFG_RDATA     (CFG_RDATA),
  .CFG_RVALID    (CFG_RVALID),
  .SYNC_MASK     (SYNC_MASK),
  .CLK_OUT       (CLK_OUT),
  .CRC_EN        (CRC_EN),
  .RX_ADDR_VALID (RX_ADDR_VALID),
  .RX_ADDR       (RX_ADDR),
  .ADDR_ACCEPT   (ADDR_ACCEPT),
  .ADDR_REJECT   (ADDR_REJECT),
  .CRC_DONE      (CRC_DONE),
  .CRC_PASS      (CRC_PASS),
  .FIFO_CLEAR    (FIFO_CLEAR)
);
`default_nettype wire

// [test/scb_host.sv]
// Host model: byte reads and writes on the register port.
// Assumes one access at a time, launched on falling edges.
`timescale 1ns/100ps
`default_nettype none
module scb_host
(
  // Clock
  input  wire logic       clk,
  // Register port
  output var  logic       wr,
  output var  logic       rd,
  output var  logic [7:0] addr,
  output var  logic [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  // Idle port at time zero
  initial
  begin
    {wr, rd, addr, wdata} = 18'h0_0000;
  end
  // Reserved bits always go out at their defaults
  function automatic logic [7:0] fix(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h12, 8'h1A: return d & 8'hFE;
      8'h1B: return d & 8'hFC;
      8'h1F: return d & 8'hC0;
      default: return d;
    endcase
  endfunction
  // One write; lines scrambled after so stale data never looks valid
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr, addr, wdata} = {1'b1, a, fix(a, d)};
    @(negedge clk);
    {wr, addr, wdata} = {1'b0, ~addr, ~wdata};
  endtask
  // One read; valid flag returned beside the data
  task automatic rd_reg(input logic [7:0] a, output logic [8:0] q);
    @(negedge clk);
    {rd, addr} = {1'b1, a};
    @(negedge clk);
    q = {rvalid, rdata};
    {rd, addr} = {1'b0, ~a};
  endtask
endmodule // scb_host
`default_nettype wire

// [test/tb.sv]
// Self-checking bench for the configuration register bank.
// Assumes scb_host drives the port and the checker is bound in.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) \
  begin tests_run++; if ((s) !== (e)) begin mismatches++; \
  $display("ERROR %s exp %0h got %0h", n, e, s); end end
module tb;
  import scb_pkg::*;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        wr, rd, rv, se, ck, man, pv, wh, ce, sb, lv, av, acc, fc, cd, cp, le;
  logic [7:0]  ad, wd, rdat, ax, d;
  logic [31:0] sm, sw, v;
  logic [3:0]  cut;
  logic [2:0]  pw;
  logic [6:0]  pl, ln;
  logic [1:0]  pre, tol;
  logic [8:0]  got;
  logic [7:0]  sh [0:39];
  logic [7:0]  ckv [0:3] = '{8'h80, 8'h8C, 8'hFC, 8'h3C};
  int          i, r, seed, cyc, mismatches, tests_run;
  scb_regbank uut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CFG_WR(wr), .CFG_RD(rd),
    .CFG_ADDR(ad), .CFG_WDATA(wd), .CFG_RDATA(rdat), .CFG_RVALID(rv), .SYNC_ENABLE(se),
    .SYNC_TOLERANCE(tol), .SYNC_WORD(sw), .SYNC_MASK(sm), .TX_INTERP_CUTOFF(cut),
    .TX_POWER(pw), .CLK_OUT(ck), .MANCHESTER_EN(man), .PKT_VARIABLE(pv),
    .PAYLOAD_LEN(pl), .PREAMBLE_SIZE(pre), .WHITEN_EN(wh), .CRC_EN(ce),
    .FIFO_STBY_READ(sb), .RX_LEN_VALID(lv), .RX_LEN(ln), .RX_LEN_ERROR(le),
    .RX_ADDR_VALID(av), .RX_ADDR(ax), .ADDR_ACCEPT(acc), .ADDR_REJECT(),
    .CRC_DONE(cd), .CRC_PASS(cp), .FIFO_CLEAR(fc));
  scb_host host (.clk(clk_sys), .wr(wr), .rd(rd), .addr(ad), .wdata(wd),
    .rdata(rdat), .rvalid(rv));
  // Mapped addresses read back their shadow, the rest read zero
  function automatic logic [7:0] er(int a);
    return (a == 18 || (a >= 22 && a <= 31)) ? sh[a] : 8'h00;
  endfunction
  // Expected filter verdict for mode, node and packet address
  function automatic logic fa(logic [1:0] m, logic [7:0] n, logic [7:0] a);
    return m == 2'h0 || a == n || (m[1] && a == 8'h00) || (m == 2'h3 && a == 8'hFF);
  endfunction
  // Shadow of every register at its reset value
  task automatic sh_init;
    for (int k = 0; k < 40; k++)
      sh[k] = 8'h00;
    sh[18] = SCB_RST_SYNC_DETECT;
    sh[26] = SCB_RST_TX_SET;
    sh[27] = SCB_RST_CLKOUT_SET;
    sh[30] = SCB_RST_PKT_FORMAT;
  endtask
  // Verdict and end of run
  task automatic stop_test;
    if (mismatches == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always #50 clk_sys = ~clk_sys;
  // Hang guard well beyond the planned run
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 32'h0000_4E20)
    begin
      mismatches++;
      stop_test();
    end
  end
  // Main sequence
  initial
  begin
    {lv, ln, av, ax, cd, cp} = 19'h0_0000;
    seed = 6;
    sh_init();
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    sys_rst = 1'b0;
    `CHK("rst_tx", {4'h7, 3'h1}, {cut, pw})
    `CHK("rst_fmt", {1'b0, 1'b0, 2'h2}, {man, pv, pre})
    `CHK("rst_opt", {1'b0, 1'b1, 1'b0}, {wh, ce, sb})
    `CHK("rst_sync", {1'b0, 2'h0, 32'hFFFF_FFFF}, {se, tol, sm})
    // Reset readback, then random writes with reserved bits kept
    for (r = 0; r < 3; r++)
      for (i = 0; i < 40; i++)
      begin
        if (r > 0)
        begin
          v = $random(seed);
          host.wr_reg(8'(i), v[7:0]);
          d = host.fix(8'(i), v[7:0]);
          if (i == 30) d[0] = sh[30][0];
          sh[i] = d;
        end
        host.rd_reg(8'(i), got);
        `CHK("read", {1'b1, er(i)}, got)
      end
    `CHK("sync", {sh[22], sh[23], sh[24], sh[25]}, sw)
    `CHK("sync_set", {sh[18][5], sh[18][2:1]}, {se, tol})
    `CHK("tx", sh[26][7:1], {cut, pw})
    `CHK("coding", sh[28], {man, pl})
    `CHK("pkt", sh[30][7:3], {pv, pre, wh, ce})
    `CHK("stby", sh[31][6], sb)
    for (r = 0; r < 4; r++)
    begin
      host.wr_reg(SCB_ADDR_SYNC_DETECT, {3'h1, 2'(r), 3'h0});
      repeat (2) @(negedge clk_sys);
      `CHK("mask", ~(32'hFFFF_FFFF >> (8 * (r + 1))), sm)
      `CHK("sync_on", 1'b1, se)
    end
    // Every filter mode against node, both broadcasts and another
    for (r = 0; r < 4; r++)
    begin
      v = $random(seed);
      host.wr_reg(SCB_ADDR_NODE, v[7:0]);
      host.wr_reg(SCB_ADDR_PKT_FORMAT, {sh[30][7:3], 2'(r), 1'b0});
      for (i = 0; i < 4; i++)
      begin
        d = (i == 0) ? v[7:0] : (i == 1) ? 8'h00 : (i == 2) ? 8'hFF : v[15:8];
        @(negedge clk_sys);
        {av, ax} = {1'b1, d};
        @(negedge clk_sys);
        av = 1'b0;
        `CHK("accept", fa(2'(r), v[7:0], d), acc)
      end
    end
    // Back-to-back random events, judged by the checker
    repeat (300)
    begin
      @(negedge clk_sys);
      v = $random(seed);
      {av, ax, lv, ln, cd, cp} = v[18:0];
    end
    @(negedge clk_sys);
    {av, lv, cd} = 3'h0;
    // Length limit: exact in fixed format, ceiling in variable format
    for (r = 0; r < 6; r++)
    begin
      host.wr_reg(SCB_ADDR_PKT_FORMAT, {r[0], sh[30][6:1], 1'b0});
      v = $random(seed);
      @(negedge clk_sys);
      ln = (r < 2) ? sh[28][6:0] : (r < 4) ? sh[28][6:0] + 7'h01 : v[6:0];
      lv = 1'b1;
      @(negedge clk_sys);
      lv = 1'b0;
      `CHK("len_err", r[0] ? ln > sh[28][6:0] : ln != sh[28][6:0], le)
    end
    // CRC verdicts with check on and off, auto-clear on and off
    for (r = 0; r < 8; r++)
    begin
      sh[30][3] = r[2];
      host.wr_reg(SCB_ADDR_PKT_FORMAT, {sh[30][7:1], !r[0]});
      host.wr_reg(SCB_ADDR_FIFO_CTRL, {r[1], 7'h00});
      @(negedge clk_sys);
      {cd, cp} = {1'b1, r[0]};
      @(negedge clk_sys);
      cd = 1'b0;
      `CHK("crc_on", r[2], ce)
      `CHK("clear", r[2] && !r[1] && !r[0], fc)
      host.wr_reg(SCB_ADDR_PKT_FORMAT, {sh[30][7:1], !r[0]});
      host.rd_reg(SCB_ADDR_PKT_FORMAT, got);
      `CHK("status", {1'b1, sh[30][7:1], r[0]}, got)
    end
    // Clock output at divider zero, three, 31 and switched off
    for (r = 0; r < 4; r++)
    begin
      host.wr_reg(SCB_ADDR_CLKOUT_SET, ckv[r]);
      repeat (150) @(negedge clk_sys);
    end
    `CHK("clk_off", 1'b0, ck)
    // Reset in mid-run must bring every register back
    sys_rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    sh_init();
    for (i = 0; i < 40; i++)
    begin
      host.rd_reg(8'(i), got);
      `CHK("rst_read", {1'b1, er(i)}, got)
    end
    stop_test();
  end
endmodule // tb
`default_nettype wire
